/* pkg/iic_pkg.sv */
// Purpose: Shared constants and types of the two-wire bus controller
// Assumes: System clock of 10 MHz
// Notes: Quarter-bit counts derive from the clock period and bus rates
package iic_pkg;

  // ----------------------------------------------------------------
  // Clock and bus rates
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RATE_KBPS_STD = 100;
  localparam int RATE_KBPS_FAST = 400;
  localparam int RATE_KBPS_PLUS = 1700;
  localparam int QCNT_W = 5;

  // Quarter of a bit period in clock cycles, rounded up, at least one
  localparam int DIV_STD = RATE_KBPS_STD * 4 * CLK_PERIOD_NS;
  localparam int DIV_FAST = RATE_KBPS_FAST * 4 * CLK_PERIOD_NS;
  localparam int DIV_PLUS = RATE_KBPS_PLUS * 4 * CLK_PERIOD_NS;
  localparam int QTR_STD_I = (1000000 + DIV_STD - 1) / DIV_STD;
  localparam int QTR_FAST_I = (1000000 + DIV_FAST - 1) / DIV_FAST;
  localparam int QTR_PLUS_I = (1000000 + DIV_PLUS - 1) / DIV_PLUS;
  localparam logic [QCNT_W-1:0] QTR_STD =
    QCNT_W'((QTR_STD_I < 1) ? 1 : QTR_STD_I);
  localparam logic [QCNT_W-1:0] QTR_FAST =
    QCNT_W'((QTR_FAST_I < 1) ? 1 : QTR_FAST_I);
  localparam logic [QCNT_W-1:0] QTR_PLUS =
    QCNT_W'((QTR_PLUS_I < 1) ? 1 : QTR_PLUS_I);

  // ----------------------------------------------------------------
  // Speed grades
  // ----------------------------------------------------------------
  localparam logic [1:0] SPEED_STD = 2'h0;
  localparam logic [1:0] SPEED_FAST = 2'h1;
  localparam logic [1:0] SPEED_PLUS = 2'h2;

  // ----------------------------------------------------------------
  // Address fields and write buffer depth
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [3:0] RSV_LOW = 4'h0;
  localparam logic [3:0] RSV_HIGH = 4'hf;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BYTE, ST_LOAD, ST_STOP
  } iic_state_t;

  typedef enum logic [1:0] {
    KIND_ADDR, KIND_WRITE, KIND_READ
  } iic_kind_t;

endpackage

/* hdl/iic_fifo.sv */
// Purpose: Small FIFO for bytes waiting to go onto the bus
// Assumes: DEPTH is a power of two
// Notes: Ready and valid come from registered flags
`timescale 1ns/1ps
`default_nettype none
module iic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic not_full_q;
  logic not_empty_q;
  wire push = in_valid_i && not_full_q;
  wire pop = not_empty_q && out_ready_i;

  // ----------------------------------------------------------------
  // Flags and pointers
  // ----------------------------------------------------------------
  assign count_d = (push && !pop) ? count_q + (AW+1)'(1) :
                   (pop && !push) ? count_q - (AW+1)'(1) : count_q;
  assign in_ready_o = not_full_q;
  assign out_valid_o = not_empty_q;
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      not_full_q <= 1'h1;
      not_empty_q <= 1'h0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      count_q <= count_d;
      not_full_q <= (count_d != FULL_CNT);
      not_empty_q <= (count_d != '0);
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) mem_q[wr_q] <= in_data_i;
  end

endmodule
`default_nettype wire

/* hdl/iic_ctrl.sv */
// Purpose: Controller for a two-wire bus reached across an isolator
// Assumes: Single controller on the local side of the isolator
// Notes: Lines are open drain; enables high mean pull low
`timescale 1ns/1ps
`default_nettype none
module iic_ctrl #(
  parameter int DATA_W = 8,
  parameter int DEPTH = iic_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic [iic_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic cmd_read_i,
  input wire logic [7:0] cmd_len_i,
  input wire logic cmd_stop_i,
  input wire logic [1:0] cmd_speed_i,
  output logic cmd_ready_o,
  // Write data
  input wire logic wr_valid_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  output logic wr_ready_o,
  // Read data and status
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  output logic done_o,
  output logic nack_o,
  output logic addr_err_o,
  output logic busy_o,
  output logic bus_held_o,
  // Local clock line
  input wire logic local_clock_line_i,
  output logic local_clock_line_o,
  output logic local_clock_line_oe_o,
  // Local data line
  input wire logic local_data_line_i,
  output logic local_data_line_o,
  output logic local_data_line_oe_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic iic_reserved(
    input logic [iic_pkg::ADDR_W-1:0] addr
  );
    iic_reserved = (addr[6:3] == iic_pkg::RSV_LOW) ||
                   (addr[6:3] == iic_pkg::RSV_HIGH);
  endfunction

  function automatic logic [iic_pkg::QCNT_W-1:0] iic_qtr(
    input logic [1:0] speed
  );
    iic_qtr = (speed == iic_pkg::SPEED_PLUS) ? iic_pkg::QTR_PLUS :
              (speed == iic_pkg::SPEED_FAST) ? iic_pkg::QTR_FAST :
              iic_pkg::QTR_STD;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iic_pkg::iic_state_t state_q, state_d;
  iic_pkg::iic_kind_t kind_q, kind_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [iic_pkg::QCNT_W-1:0] qcnt_q, qcnt_d;
  logic [8:0] tx_q, tx_d;
  logic [8:0] rx_q, rx_d;
  logic [7:0] rem_q, rem_d;
  logic [iic_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic rw_q, rw_d;
  logic stop_q, stop_d;
  logic [1:0] speed_q, speed_d;
  logic owned_q, owned_d;
  logic scl_oe_q, scl_oe_d;
  logic sda_oe_q, sda_oe_d;
  logic rd_valid_q, rd_valid_d;
  logic [DATA_W-1:0] rd_data_q, rd_data_d;
  logic done_q, done_d;
  logic nack_q, nack_d;
  logic err_q, err_d;
  logic ready_q;
  logic busy_q;
  logic reload;
  logic pop;
  logic scl_m_q, scl_s_q;
  logic sda_m_q, sda_s_q;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;

  wire tick = (qcnt_q == '0);
  wire take = (state_q == iic_pkg::ST_IDLE) && cmd_valid_i && ready_q;
  wire [8:0] rx_next = {rx_q[7:0], sda_s_q};
  wire byte_end = (state_q == iic_pkg::ST_BYTE) && (phase_q == 2'h3) &&
                  tick && (bit_q == 4'h8);

  // ----------------------------------------------------------------
  // Write byte buffer
  // ----------------------------------------------------------------
  iic_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(wr_valid_i),
    .in_data_i(wr_data_i),
    .in_ready_o(wr_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(pop)
  );

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_m_q <= 1'h1;
      scl_s_q <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
    end else begin
      scl_m_q <= local_clock_line_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= local_data_line_i;
      sda_s_q <= sda_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Quarter-bit timer
  // ----------------------------------------------------------------
  assign qcnt_d = reload ? iic_qtr(speed_d) - iic_pkg::QCNT_W'(1) :
                  tick ? qcnt_q : qcnt_q - iic_pkg::QCNT_W'(1);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    phase_d = phase_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rem_d = rem_q;
    addr_d = addr_q;
    rw_d = rw_q;
    stop_d = stop_q;
    speed_d = speed_q;
    owned_d = owned_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rd_valid_d = 1'h0;
    rd_data_d = rd_data_q;
    done_d = 1'h0;
    nack_d = 1'h0;
    err_d = 1'h0;
    reload = 1'h0;
    pop = 1'h0;
    case (state_q)
      iic_pkg::ST_IDLE: begin
        sda_oe_d = 1'h0;
        if (take) begin
          if (iic_reserved(cmd_addr_i)) begin
            err_d = 1'h1;
          end else begin
            addr_d = cmd_addr_i;
            rw_d = cmd_read_i;
            rem_d = cmd_len_i;
            stop_d = cmd_stop_i;
            speed_d = cmd_speed_i;
            tx_d = {cmd_addr_i, cmd_read_i, 1'h1};
            kind_d = iic_pkg::KIND_ADDR;
            state_d = iic_pkg::ST_START;
            phase_d = 2'h0;
            reload = 1'h1;
          end
        end
      end
      iic_pkg::ST_START: begin
        case (phase_q)
          2'h0: begin
            sda_oe_d = 1'h0;
            if (tick) begin
              scl_oe_d = 1'h0;
              phase_d = 2'h1;
            end
          end
          2'h1: begin
            if (scl_s_q && sda_s_q) begin
              phase_d = 2'h2;
              reload = 1'h1;
            end
          end
          2'h2: begin
            if (tick) begin
              sda_oe_d = 1'h1;
              phase_d = 2'h3;
              reload = 1'h1;
            end
          end
          default: begin
            if (tick) begin
              scl_oe_d = 1'h1;
              owned_d = 1'h1;
              state_d = iic_pkg::ST_BYTE;
              phase_d = 2'h0;
              bit_d = 4'h0;
              reload = 1'h1;
            end
          end
        endcase
      end
      iic_pkg::ST_BYTE: begin
        case (phase_q)
          2'h0: begin
            sda_oe_d = ~tx_q[8];
            if (tick) begin
              phase_d = 2'h1;
              reload = 1'h1;
            end
          end
          2'h1: begin
            if (tick) begin
              scl_oe_d = 1'h0;
              phase_d = 2'h2;
              reload = 1'h1;
            end
          end
          2'h2: begin
            if (scl_s_q && tick) begin
              phase_d = 2'h3;
              reload = 1'h1;
            end
          end
          default: begin
            if (tick) begin
              scl_oe_d = 1'h1;
              rx_d = rx_next;
              tx_d = {tx_q[7:0], 1'h1};
              bit_d = bit_q + 4'h1;
              phase_d = 2'h0;
              reload = 1'h1;
            end
          end
        endcase
        if (byte_end) begin
          bit_d = 4'h0;
          case (kind_q)
            iic_pkg::KIND_ADDR: begin
              if (sda_s_q) begin
                nack_d = 1'h1;
                state_d = iic_pkg::ST_STOP;
              end else if (rem_q == 8'h00) begin
                state_d = stop_q ? iic_pkg::ST_STOP : iic_pkg::ST_IDLE;
                done_d = !stop_q;
              end else if (rw_q == iic_pkg::DIR_READ) begin
                kind_d = iic_pkg::KIND_READ;
                tx_d = {8'hff, rem_q == 8'h01};
              end else begin
                kind_d = iic_pkg::KIND_WRITE;
                state_d = iic_pkg::ST_LOAD;
              end
            end
            iic_pkg::KIND_WRITE: begin
              rem_d = rem_q - 8'h01;
              if (sda_s_q) begin
                nack_d = 1'h1;
                state_d = iic_pkg::ST_STOP;
              end else if (rem_q == 8'h01) begin
                state_d = stop_q ? iic_pkg::ST_STOP : iic_pkg::ST_IDLE;
                done_d = !stop_q;
              end else begin
                state_d = iic_pkg::ST_LOAD;
              end
            end
            default: begin
              rd_valid_d = 1'h1;
              rd_data_d = rx_next[8:1];
              rem_d = rem_q - 8'h01;
              if (rem_q == 8'h01) begin
                state_d = stop_q ? iic_pkg::ST_STOP : iic_pkg::ST_IDLE;
                done_d = !stop_q;
              end else begin
                tx_d = {8'hff, rem_q == 8'h02};
              end
            end
          endcase
        end
      end
      iic_pkg::ST_LOAD: begin
        if (fifo_valid) begin
          pop = 1'h1;
          tx_d = {fifo_data, 1'h1};
          state_d = iic_pkg::ST_BYTE;
          phase_d = 2'h0;
          bit_d = 4'h0;
          reload = 1'h1;
        end
      end
      iic_pkg::ST_STOP: begin
        case (phase_q)
          2'h0: begin
            sda_oe_d = 1'h1;
            if (tick) begin
              scl_oe_d = 1'h0;
              phase_d = 2'h1;
            end
          end
          2'h1: begin
            if (scl_s_q) begin
              phase_d = 2'h2;
              reload = 1'h1;
            end
          end
          2'h2: begin
            if (tick) begin
              sda_oe_d = 1'h0;
              phase_d = 2'h3;
              reload = 1'h1;
            end
          end
          default: begin
            if (tick) begin
              owned_d = 1'h0;
              done_d = 1'h1;
              state_d = iic_pkg::ST_IDLE;
            end
          end
        endcase
      end
      default: begin
        state_d = iic_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= iic_pkg::ST_IDLE;
      kind_q <= iic_pkg::KIND_ADDR;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      qcnt_q <= '0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      rem_q <= 8'h00;
      addr_q <= '0;
      rw_q <= iic_pkg::DIR_WRITE;
      stop_q <= 1'h1;
      speed_q <= iic_pkg::SPEED_STD;
      owned_q <= 1'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      qcnt_q <= qcnt_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rem_q <= rem_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      stop_q <= stop_d;
      speed_q <= speed_d;
      owned_q <= owned_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'h0;
      rd_data_q <= '0;
      done_q <= 1'h0;
      nack_q <= 1'h0;
      err_q <= 1'h0;
      ready_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      done_q <= done_d;
      nack_q <= nack_d | (nack_q & ~done_d & (state_q != iic_pkg::ST_IDLE));
      err_q <= err_d;
      ready_q <= (state_d == iic_pkg::ST_IDLE) && !take;
      busy_q <= (state_d != iic_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready_o = ready_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;
  assign done_o = done_q;
  assign nack_o = nack_q;
  assign addr_err_o = err_q;
  assign busy_o = busy_q;
  assign bus_held_o = owned_q;
  assign local_clock_line_o = 1'h0;
  assign local_data_line_o = 1'h0;
  assign local_clock_line_oe_o = scl_oe_q;
  assign local_data_line_oe_o = sda_oe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_data_change: assert property (@(posedge clock_i) disable iff (rst_i)
    ($changed(sda_oe_q) && !$past(scl_oe_q)) |->
      ($past(state_q) == iic_pkg::ST_START ||
       $past(state_q) == iic_pkg::ST_STOP))
    else $error("data moved while clock high outside start or stop");

  a_start_shape: assert property (@(posedge clock_i) disable iff (rst_i)
    ($rose(sda_oe_q) && !scl_oe_q) |->
      ($past(state_q) == iic_pkg::ST_START ##[1:30] scl_oe_q))
    else $error("start not formed under released clock");

  a_stop_shape: assert property (@(posedge clock_i) disable iff (rst_i)
    ($fell(sda_oe_q) && !$past(scl_oe_q)) |->
      ($past(state_q) == iic_pkg::ST_STOP))
    else $error("data rose under high clock outside stop");

  a_idle_seen: assert property (@(posedge clock_i) disable iff (rst_i)
    ($rose(sda_oe_q) && !scl_oe_q) |-> $past(scl_s_q && sda_s_q, 2))
    else $error("start issued while bus not idle");

  a_addr_first: assert property (@(posedge clock_i) disable iff (rst_i)
    ($past(state_q) == iic_pkg::ST_START && state_q == iic_pkg::ST_BYTE) |->
      (tx_q == {addr_q, rw_q, 1'h1} && kind_q == iic_pkg::KIND_ADDR))
    else $error("address byte not loaded at start");

  a_ack_release: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == iic_pkg::ST_BYTE && bit_q == 4'h8 && phase_q == 2'h3 &&
     kind_q != iic_pkg::KIND_READ) |-> !sda_oe_q)
    else $error("data not released for target acknowledge");

  a_ack_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == iic_pkg::ST_BYTE && phase_q == 2'h3 &&
     $past(phase_q) == 2'h3) |-> $stable(sda_oe_q))
    else $error("data moved during clock high phase");

  a_read_ack: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == iic_pkg::ST_BYTE && kind_q == iic_pkg::KIND_READ &&
     bit_q == 4'h8 && phase_q == 2'h3 && rem_q > 8'h01) |-> sda_oe_q)
    else $error("read byte before last not acknowledged");

  a_last_nack: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == iic_pkg::ST_BYTE && kind_q == iic_pkg::KIND_READ &&
     bit_q == 4'h8 && phase_q == 2'h3 && rem_q == 8'h01) |-> !sda_oe_q)
    else $error("last read byte was acknowledged");

  a_fifo_stall: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == iic_pkg::ST_LOAD && !fifo_valid) |=>
      (state_q == iic_pkg::ST_LOAD && scl_oe_q))
    else $error("write went on without a byte");

  a_clock_own: assert property (@(posedge clock_i) disable iff (rst_i)
    scl_oe_q |-> (state_q != iic_pkg::ST_IDLE || owned_q))
    else $error("clock held low without owning the bus");

  a_end_kind: assert property (@(posedge clock_i) disable iff (rst_i)
    (done_q && !owned_q) |-> ($past(state_q, 2) == iic_pkg::ST_STOP))
    else $error("transfer released bus without stop");

  a_reserved: assert property (@(posedge clock_i) disable iff (rst_i)
    (take && iic_reserved(cmd_addr_i)) |=>
      (addr_err_o && state_q == iic_pkg::ST_IDLE))
    else $error("reserved address not refused");

endmodule
`default_nettype wire

/* verification/iic_target_model.sv */
// Purpose: Isolator and one target on the far side of the bus
// Assumes: Pull-ups on all lines, no clock stretching
// Notes: Far lines lag the local lines by DLY
`timescale 1ns/1ps
`default_nettype none
module iic_target_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int DLY = 20
) (
  // Local side lines
  input wire logic local_clock_line_i,
  input wire logic local_data_line_i,
  output logic local_data_line_pull_o
);
  // ------
  // Isolator
  // ------
  logic far_clock_line, far_data_line, act, adr, rd, mack;
  logic pull = 1'b0;
  logic [7:0] sh, tx;
  logic [7:0] wr_q[$], rd_q[$];
  int bits = 0;
  int starts = 0;
  int stops = 0;
  int nacks = 0;
  assign #DLY far_clock_line = local_clock_line_i;
  assign #DLY far_data_line = local_data_line_i;
  assign #DLY local_data_line_pull_o = pull;
  // ------
  // Target
  // ------
  always @(negedge far_data_line) if (far_clock_line === 1'b1) begin
    starts++;
    act = 1'b1;
    adr = 1'b1;
    bits = 0;
  end
  always @(posedge far_data_line) if (far_clock_line === 1'b1) begin
    stops++;
    act = 1'b0;
    pull = 1'b0;
  end
  always @(posedge far_clock_line) if (act) begin
    if (bits < 8) sh = {sh[6:0], far_data_line};
    else mack = !far_data_line;
    bits++;
  end
  always @(negedge far_clock_line) if (act) begin
    pull = 1'b0;
    if (bits == 8 && adr) begin
      rd = sh[0];
      act = (sh[7:1] == ADDR);
      pull = act;
    end else if (bits == 8 && !rd) begin
      wr_q.push_back(sh);
      pull = 1'b1;
    end else if (bits == 9) begin
      bits = 0;
      if (!adr && rd && !mack) nacks++;
      if (!adr && rd && !mack) act = 1'b0;
      adr = 1'b0;
      if (act && rd) tx = rd_q.size() ? rd_q.pop_front() : 8'hff;
    end
    if (act && rd && !adr && bits < 8) pull = !tx[7 - bits];
  end
endmodule
`default_nettype wire

/* verification/isolated_i2c_transaction_protocol_test.sv */
// Purpose: Self-checking bench of the two-wire controller
// Assumes: Target model at address TA behind the isolator
// Notes: All speeds, refusal, write, read, repeated start
`timescale 1ns/1ps
`default_nettype none
module isolated_i2c_transaction_protocol_test;
  // ------
  // Signals
  // ------
  localparam logic [6:0] TA = 7'h2a;
  logic clock_i, rst_i, cmd_valid_i, cmd_read_i, cmd_stop_i, wr_valid_i;
  logic [6:0] cmd_addr_i;
  logic [7:0] cmd_len_i, wr_data_i, rd_data_o, b;
  logic [1:0] cmd_speed_i;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, addr_err_o;
  logic busy_o, bus_held_o, scl_oe, sda_oe, pull, nk;
  wire logic scl, sda;
  int mismatches = 0;
  int samples_checked = 0;
  int i, k, sb, pb, nb;
  logic [7:0] exp_q[$], wq[$];
  assign scl = !scl_oe;
  assign sda = !sda_oe && !pull;
  iic_ctrl dut (.clock_i(clock_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_addr_i(cmd_addr_i),
    .cmd_read_i(cmd_read_i), .cmd_len_i(cmd_len_i),
    .cmd_stop_i(cmd_stop_i), .cmd_speed_i(cmd_speed_i),
    .cmd_ready_o(cmd_ready_o), .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o),
    .nack_o(nack_o), .addr_err_o(addr_err_o), .busy_o(busy_o),
    .bus_held_o(bus_held_o), .local_clock_line_i(scl),
    .local_clock_line_o(), .local_clock_line_oe_o(scl_oe),
    .local_data_line_i(sda), .local_data_line_o(),
    .local_data_line_oe_o(sda_oe));
  iic_target_model #(.ADDR(TA)) tgt (.local_clock_line_i(scl),
    .local_data_line_i(sda), .local_data_line_pull_o(pull));
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic push(input logic [7:0] d);
    wr_valid_i <= 1'b1;
    wr_data_i <= d;
    @(posedge clock_i);
    while (wr_ready_o !== 1'b1) @(posedge clock_i);
  endtask
  task automatic run(input logic [6:0] a, input logic r, input logic s);
    int t;
    t = 0;
    cmd_addr_i <= a;
    cmd_read_i <= r;
    cmd_len_i <= r ? 8'h03 : 8'h04;
    cmd_stop_i <= s;
    cmd_speed_i <= 2'(k);
    cmd_valid_i <= 1'b1;
    @(posedge clock_i);
    while (cmd_ready_o !== 1'b1) @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    nk = 1'b0;
    do begin
      @(posedge clock_i);
      t++;
      if (t == 1) chk(8'(busy_o), 8'(a[6:3] != 4'h0 && a[6:3] != 4'hf));
      if (nack_o === 1'b1) nk = 1'b1;
      if (rd_valid_o === 1'b1) chk(rd_data_o, exp_q.pop_front());
    end while (done_o !== 1'b1 && addr_err_o !== 1'b1 && t < 20000);
    chk(8'(t < 20000), 8'h01);
  endtask
  task print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = !clock_i;
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    mismatches++;
    print_verdict();
  end
  initial begin
    rst_i = 1'b1;
    {cmd_valid_i, cmd_read_i, cmd_stop_i, wr_valid_i} = 4'h0;
    {cmd_addr_i, cmd_len_i, wr_data_i, cmd_speed_i} = 25'h0;
    k = 0;
    void'($urandom(84));
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    sb = tgt.starts;
    pb = tgt.stops;
    run(7'h05, 1'b0, 1'b1);
    chk(8'(addr_err_o), 8'h01);
    run(7'h7c, 1'b1, 1'b1);
    chk(8'(addr_err_o), 8'h01);
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 4; i++) begin
        b = 8'($urandom);
        wq.push_back(b);
        if (k != 1 || i < 3) push(b);
      end
      wr_valid_i <= 1'b0;
      @(posedge clock_i);
      chk(8'(wr_ready_o), 8'(k == 1));
      if (k == 1) fork
        begin
          repeat (1500) @(posedge clock_i);
          push(wq[3]);
          wr_valid_i <= 1'b0;
        end
      join_none
      run(TA, 1'b0, 1'b1);
      chk(8'(nk), 8'h00);
      for (i = 0; i < 4; i++) chk(tgt.wr_q.pop_front(), wq.pop_front());
      for (i = 0; i < 3; i++) begin
        b = 8'($urandom);
        tgt.rd_q.push_back(b);
        exp_q.push_back(b);
      end
      nb = tgt.nacks;
      run(TA, 1'b1, 1'b0);
      chk(8'(bus_held_o), 8'h01);
      chk(8'(tgt.nacks - nb), 8'h01);
      chk(8'(exp_q.size()), 8'h00);
      run(TA + 7'h01, 1'b1, 1'b1);
      chk(8'(nk), 8'h01);
    end
    chk(8'(tgt.starts - sb), 8'h09);
    chk(8'(tgt.stops - pb), 8'h06);
    print_verdict();
  end
endmodule
`default_nettype wire
